// >>> core/serial_audio_port.v
// Serial audio port with clock-role logic, four input and four output lines
// Contract
// (R1) Master role drives master, bit, frame clocks
// (R2) Slave role takes all three clocks in
// (R3) Role comes from control register clock_role_and_format_control
// (R4) Master clock stays within 6 to 24.576 MHz
// (R5) Slave works with any master clock ratio
// (R6) Outside system handles clock faults itself
// (R7) Four serial inputs and four serial outputs
// (R8) Frame rates 32 to 192 kHz accepted
// (R9) Word size 16, 20, 24 or 32
// (R10) All lines: left, right justified, I2S
// (R11) Only first lines carry 4/6/8 channel TDM
// (R12) Formats and word size from register clock_role_and_format_control
// (R13) One input format, one output format
// (R14) Bit clock 64, 128, 192, 256 frames
// (R15) Control writes set port mode and clocks
// (R16) Separate receive and transmit bit clock outputs
// (R17) Received samples delivered as 48-bit words
// (R18) Output samples taken as 32-bit words, four buses
// (R19) MSB first; I2S one bit delayed
// (R20) Master bit/frame clocks derived from master clock
`include "sap_defs.vh"

module serial_audio_port #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  input wire clock_in,
  input wire rst_in,
  input wire ce_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  output reg [31:0] reg_rdata_out,
  input wire master_clock_input,
  output wire master_clock_out,
  input wire bit_clock_in,
  output wire receive_bit_clock_out,
  output wire transmit_bit_clock_out,
  input wire frame_clock_in,
  output wire frame_clock_out,
  output wire frame_clock_oe_out,
  input wire serial_in_primary,
  input wire serial_in_second,
  input wire serial_in_third,
  input wire serial_in_fourth,
  output wire serial_out_primary,
  output wire serial_out_second,
  output wire serial_out_third,
  output wire serial_out_fourth,
  input wire [127:0] tx_word_in,
  input wire tx_valid_in,
  output wire tx_ready_out,
  output wire [191:0] rx_word_out,
  output wire [3:0] rx_valid_out,
  output reg [2:0] rx_chan_out
);

  // ----------------------------------------------------------------
  // Control register and decoded fields
  // ----------------------------------------------------------------
  reg [`CTRL_BITS-1:0] ctrl_q; // Role, formats, ratios, dividers
  reg under_q; // Sticky transmit underrun

  wire master = ctrl_q[`F_MASTER]; // R3
  wire [1:0] word_code = ctrl_q[`F_WORD_LO+1:`F_WORD_LO]; // R12
  wire [1:0] in_fmt = ctrl_q[`F_IN_LO+1:`F_IN_LO]; // R13
  wire [1:0] out_fmt = ctrl_q[`F_OUT_LO+1:`F_OUT_LO]; // R13
  wire [1:0] ratio_code = ctrl_q[`F_RATIO_LO+1:`F_RATIO_LO];
  wire [1:0] tdm_code = ctrl_q[`F_TDM_LO+1:`F_TDM_LO];
  wire [1:0] mdiv = ctrl_q[`F_MDIV_LO+1:`F_MDIV_LO];
  wire [3:0] bdiv = ctrl_q[`F_BDIV_LO+3:`F_BDIV_LO];

  // Word length in bits
  wire [8:0] wlen = (word_code == 2'h0) ? `WLEN_16 : // R9
                    (word_code == 2'h1) ? `WLEN_20 :
                    (word_code == 2'h2) ? `WLEN_24 : `WLEN_32;
  // Bit clocks per frame for two-channel framing
  wire [8:0] ratio_fld = {1'b0, ratio_code, 6'h00} + `RATIO_STEP; // R14
  // Channel count of a multiplexed frame
  wire [3:0] tdm_ch = (tdm_code == 2'h0) ? 4'h4 : (tdm_code == 2'h1) ? 4'h6 : 4'h8; // R11
  wire any_tdm = (in_fmt == `FMT_TDM) | (out_fmt == `FMT_TDM);
  // Frame length follows channel count when multiplexed
  wire [8:0] frame_len = any_tdm ? {tdm_ch, 5'h00} : ratio_fld; // R14
  wire [8:0] half_len = {1'b0, ratio_fld[8:1]};
  // Clamp keeps the generated master clock inside its legal band
  wire [1:0] mdiv_eff = (mdiv > `MDIV_MAX) ? `MDIV_MAX : mdiv; // R4

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [6:0] sync1_q; // First stage, read only by second stage
  reg [6:0] sync2_q; // Second stage
  wire [6:0] raw_pins = {master_clock_input, frame_clock_in, bit_clock_in,
                         serial_in_fourth, serial_in_third, serial_in_second,
                         serial_in_primary};
  wire [3:0] sdin_s = sync2_q[3:0]; // R7
  wire bclk_s = sync2_q[4];
  wire lr_s = sync2_q[5];
  wire mclk_s = sync2_q[6];

  // Two-flop capture of every outside pin
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else if (ce_in) begin
      sync1_q <= raw_pins; // R2
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Clock generation in master role
  // ----------------------------------------------------------------
  reg [1:0] mcnt_q; // Master clock divider
  reg mclk_q; // Generated master clock
  reg [3:0] bcnt_q; // Master clock edges per bit clock half
  reg bclk_m_q; // Generated bit clock
  reg bclk_prev_q; // Last sampled bit clock in slave role
  reg [8:0] fcnt_q; // Bit position in generated frame
  reg lr_m_q; // Generated frame clock

  wire mtog = master & (mcnt_q == mdiv_eff);
  wire mrise = mtog & ~mclk_q;
  wire btog = mrise & (bcnt_q == bdiv); // R20
  wire m_rise = btog & ~bclk_m_q;
  wire m_fall = btog & bclk_m_q;
  // In slave role the sampled bit clock alone times the port, so
  // the master clock frequency need not relate to the frame rate
  wire s_rise = ~master & bclk_s & ~bclk_prev_q; // R5
  wire s_fall = ~master & ~bclk_s & bclk_prev_q; // R5
  wire rise = ce_in & (m_rise | s_rise);
  wire fall = ce_in & (m_fall | s_fall);

  wire [8:0] fcnt_inc = fcnt_q + 9'h001;
  wire [8:0] fcnt_nx = (fcnt_inc >= frame_len) ? 9'h000 : fcnt_inc;
  // Frame clock high for first slot (TDM) or first half (two-channel)
  wire lr_m_nx = any_tdm ? (fcnt_nx < `TDM_SLOT) : (fcnt_nx < half_len); // R8
  wire lr_now = master ? lr_m_nx : lr_s;

  // Dividers run only while this end owns the clocks
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mcnt_q <= 2'h0;
      mclk_q <= 1'b0;
      bcnt_q <= 4'h0;
      bclk_m_q <= 1'b0;
      bclk_prev_q <= 1'b0;
      fcnt_q <= 9'h000;
      lr_m_q <= 1'b0;
    end else if (ce_in) begin
      bclk_prev_q <= bclk_s;
      if (!master) begin
        // Idle generators in slave role
        mcnt_q <= 2'h0;
        mclk_q <= 1'b0;
        bcnt_q <= 4'h0;
        bclk_m_q <= 1'b0;
        fcnt_q <= 9'h000;
        lr_m_q <= 1'b0;
      end else begin
        mcnt_q <= mtog ? 2'h0 : mcnt_q + 2'h1; // R4
        if (mtog) begin
          mclk_q <= ~mclk_q; // R1
        end
        if (mrise) begin
          bcnt_q <= btog ? 4'h0 : bcnt_q + 4'h1; // R20
        end
        if (btog) begin
          bclk_m_q <= ~bclk_m_q; // R1
        end
        if (m_fall) begin
          fcnt_q <= fcnt_nx;
          lr_m_q <= lr_m_nx; // R20
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame position tracking, one tracker per direction
  // ----------------------------------------------------------------
  reg lr_last_q; // Frame clock at previous falling bit clock
  reg [17:0] pos_q; // Bit position: [8:0] receive, [17:9] transmit
  reg rx_win_q; // Receive bit belongs to a word
  reg rx_last_q; // Receive bit is last of its word
  reg [2:0] rx_slot_q; // Receive channel slot
  wire [17:0] pos_nx;
  wire [1:0] win_nx;
  wire [1:0] first_nx;
  wire [1:0] last_nx;
  wire [5:0] slot_nx;

  genvar d;
  generate
    for (d = 0; d < 2; d = d + 1) begin : g_dir
      wire [1:0] fmt = (d == 0) ? in_fmt : out_fmt; // R13
      wire tdm = (fmt == `FMT_TDM);
      wire fedge = tdm ? (lr_now & ~lr_last_q) : (lr_now ^ lr_last_q);
      wire [8:0] pn = fedge ? 9'h000 : pos_q[9*d+8:9*d] + 9'h001;
      wire [8:0] off = tdm ? {4'h0, pn[4:0]} : pn;
      wire chan = (fmt == `FMT_I2S) ? lr_now : ~lr_now;
      wire [2:0] slot = tdm ? pn[7:5] : {2'b00, chan};
      // Word start inside its slot for each framing
      wire [8:0] start = (fmt == `FMT_RJ) ? // R10
                         ((half_len > wlen) ? half_len - wlen : 9'h000) :
                         (fmt == `FMT_I2S) ? 9'h001 : 9'h000; // R19
      wire slot_ok = tdm ? ({1'b0, slot} < tdm_ch) : 1'b1; // R11
      wire [8:0] stop = start + wlen;
      assign pos_nx[9*d+8:9*d] = pn;
      assign slot_nx[3*d+2:3*d] = slot;
      assign win_nx[d] = slot_ok & (off >= start) & (off < stop);
      assign first_nx[d] = win_nx[d] & (off == start);
      assign last_nx[d] = win_nx[d] & (off == stop - 9'h001);
    end
  endgenerate

  // Positions move on every falling bit clock
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      lr_last_q <= 1'b0;
      pos_q <= 18'h00000;
      rx_win_q <= 1'b0;
      rx_last_q <= 1'b0;
      rx_slot_q <= 3'h0;
    end else if (fall) begin
      lr_last_q <= lr_now;
      pos_q <= pos_nx;
      rx_win_q <= win_nx[0];
      rx_last_q <= last_nx[0];
      rx_slot_q <= slot_nx[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  wire [127:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop = fall & first_nx[1]; // R18

  sap_fifo #(
    .WIDTH(128),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_tx_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .in_data_in(tx_word_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop)
  );

  // ----------------------------------------------------------------
  // Per-line receive and transmit shifters
  // ----------------------------------------------------------------
  wire [5:0] lsh = 6'h20 - wlen[5:0]; // Left-align short words
  wire [3:0] sout_q; // Serial output levels

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_line
      wire rx_act = (i == 0) | (in_fmt != `FMT_TDM); // R11
      wire tx_act = (i == 0) | (out_fmt != `FMT_TDM); // R11
      reg [31:0] rsh_q; // Receive shifter
      reg [47:0] rword_q; // Delivered word
      reg rvld_q; // Delivery strobe
      reg [31:0] tsh_q; // Transmit shifter, current bit at top
      reg so_q; // Output bit of this line
      wire [31:0] rnx = {rsh_q[30:0], sdin_s[i]};
      wire [31:0] ralign = rnx << lsh;
      assign sout_q[i] = so_q;
      assign rx_word_out[48*i+47:48*i] = rword_q;
      assign rx_valid_out[i] = rvld_q;

      // Sample on rising bit clock, MSB arrives first
      always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          rsh_q <= 32'h00000000;
          rword_q <= 48'h000000000000;
          rvld_q <= 1'b0;
        end else if (ce_in) begin
          rvld_q <= rise & rx_win_q & rx_last_q & rx_act; // R17
          if (rise & rx_win_q & rx_act) begin
            rsh_q <= rnx; // R19
          end
          if (rise & rx_win_q & rx_last_q & rx_act) begin
            rword_q <= {ralign, 16'h0000}; // R17
          end
        end
      end

      // Shift out on falling bit clock; empty buffer sends zeros
      always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          tsh_q <= 32'h00000000;
          so_q <= 1'b0;
        end else if (fall) begin
          if (first_nx[1]) begin
            tsh_q <= fifo_valid ? fifo_data[32*i+31:32*i] : 32'h00000000; // R18
            so_q <= tx_act & fifo_valid & fifo_data[32*i+31]; // R19
          end else begin
            tsh_q <= {tsh_q[30:0], 1'b0};
            so_q <= tx_act & win_nx[1] & tsh_q[30]; // R19
          end
        end
      end
    end
  endgenerate

  assign serial_out_primary = sout_q[0]; // R7
  assign serial_out_second = sout_q[1];
  assign serial_out_third = sout_q[2];
  assign serial_out_fourth = sout_q[3];

  // Slot of the word just delivered, common to all lines
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_chan_out <= 3'h0;
    end else if (rise & rx_win_q & rx_last_q) begin
      rx_chan_out <= rx_slot_q; // R17
    end
  end

  // ----------------------------------------------------------------
  // Clock pins
  // ----------------------------------------------------------------
  // Master role drives all three clocks; slave role repeats the bit
  // clock it samples on both bit clock outputs
  assign master_clock_out = master & mclk_q; // R1
  assign receive_bit_clock_out = master ? bclk_m_q : bclk_prev_q; // R16
  assign transmit_bit_clock_out = master ? bclk_m_q : bclk_prev_q; // R16
  assign frame_clock_out = lr_m_q; // R1
  assign frame_clock_oe_out = master; // R2

  // ----------------------------------------------------------------
  // Control register access
  // ----------------------------------------------------------------
  wire ctrl_hit = (reg_addr_in == `CTRL_OFFSET);
  wire under_set = fifo_pop & ~fifo_valid;
  wire under_clr = reg_wr_in & ctrl_hit & reg_wdata_in[`F_UNDER];

  // Writes to the control register set role, formats and clocks
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= `CTRL_RESET;
      under_q <= 1'b0;
    end else if (ce_in) begin
      if (reg_wr_in & ctrl_hit) begin
        ctrl_q <= reg_wdata_in[`CTRL_BITS-1:0]; // R15
      end
      // A new underrun wins over a clear in the same cycle
      under_q <= under_set | (under_q & ~under_clr);
    end
  end

  // Registered read: live pin levels and underrun above the settings
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (ce_in & reg_rd_in) begin
      if (ctrl_hit) begin
        reg_rdata_out <= {4'h0, under_q, mclk_s, receive_bit_clock_out,
                          lr_now, 7'h00, ctrl_q};
      end else begin
        reg_rdata_out <= 32'h00000000;
      end
    end
  end

endmodule

// >>> core/sap_defs.vh
// Register map, field positions, reset values and codes of the serial audio port
`ifndef SAP_DEFS_VH
`define SAP_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CTRL_OFFSET 8'h00
`define CTRL_BITS 17
`define CTRL_RESET 17'h02454

// ----------------------------------------------------------------
// Field positions of the control register
// ----------------------------------------------------------------
`define F_MASTER 0
`define F_WORD_LO 1
`define F_IN_LO 3
`define F_OUT_LO 5
`define F_RATIO_LO 7
`define F_TDM_LO 9
`define F_MDIV_LO 11
`define F_BDIV_LO 13
`define F_UNDER 27

// ----------------------------------------------------------------
// Framing codes
// ----------------------------------------------------------------
`define FMT_LJ 2'h0
`define FMT_RJ 2'h1
`define FMT_I2S 2'h2
`define FMT_TDM 2'h3

// ----------------------------------------------------------------
// Word lengths, slot length and ratio steps (bit clocks), master clock divider limit
// ----------------------------------------------------------------
`define WLEN_16 9'h010
`define WLEN_20 9'h014
`define WLEN_24 9'h018
`define WLEN_32 9'h020
`define TDM_SLOT 9'h020
`define RATIO_STEP 9'h040
`define MDIV_MAX 2'h2

`endif

// >>> core/sap_fifo.v
// Small synchronous FIFO with valid and ready on both sides

module sap_fifo #(
  parameter WIDTH = 128,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clock_in,
  input wire rst_in,
  input wire ce_in,
  input wire [WIDTH-1:0] in_data_in,
  input wire in_valid_in,
  output wire in_ready_out,
  output wire [WIDTH-1:0] out_data_out,
  output wire out_valid_out,
  input wire out_ready_in
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Entry storage
  reg [AW-1:0] wr_q; // Write pointer
  reg [AW-1:0] rd_q; // Read pointer
  reg [AW:0] cnt_q; // Fill level

  wire push = ce_in & in_valid_in & in_ready_out;
  wire pop = ce_in & out_valid_out & out_ready_in;

  assign in_ready_out = (cnt_q != DEPTH[AW:0]);
  assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_q];

  // Pointer and level update, wrapping at DEPTH
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Data write, no reset needed
  always @(posedge clock_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

endmodule

// >>> verif/sap_chk.sv
// Concurrent checks on the serial audio port pins
`include "sap_defs.vh"
module sap_chk (
  input wire clock_in,
  input wire rst_in,
  input wire ce_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire [31:0] reg_rdata_out,
  input wire master_clock_out,
  input wire receive_bit_clock_out,
  input wire transmit_bit_clock_out,
  input wire frame_clock_oe_out,
  input wire serial_out_second,
  input wire serial_out_third,
  input wire serial_out_fourth,
  input wire [3:0] rx_valid_out
);
  // ----------------------------------------------------------------
  // Format fields shadowed from control writes
  // ----------------------------------------------------------------
  reg [1:0] in_fmt_q; // Input framing
  reg [1:0] out_fmt_q; // Output framing
  wire wr_ctrl = reg_wr_in && ce_in && reg_addr_in == `CTRL_OFFSET; // Control write
  // Follow the format fields, reset values are I2S
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      in_fmt_q <= `FMT_I2S;
      out_fmt_q <= `FMT_I2S;
    end else if (wr_ctrl) begin
      in_fmt_q <= reg_wdata_in[`F_IN_LO+1:`F_IN_LO];
      out_fmt_q <= reg_wdata_in[`F_OUT_LO+1:`F_OUT_LO];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Master clock toggles within 5 cycles
  sequence mclk_edge;
    ##[0:4] $changed(master_clock_out);
  endsequence
  // TDM format held for three cycles
  sequence tdm_in_held;
    in_fmt_q == `FMT_TDM && $past(in_fmt_q, 3) == `FMT_TDM;
  endsequence
  sequence tdm_out_held;
    out_fmt_q == `FMT_TDM && $past(out_fmt_q, 3) == `FMT_TDM;
  endsequence
  AST_ROLE_FROM_REG: assert property (wr_ctrl
    |=> frame_clock_oe_out == $past(reg_wdata_in[`F_MASTER])) else $error("role not taken");
  AST_WR_OTHER_IGNORED: assert property (reg_wr_in && ce_in && reg_addr_in != 8'h00
    |=> frame_clock_oe_out == $past(frame_clock_oe_out)) else $error("stray write acted");
  AST_SLAVE_NO_MCLK: assert property (!frame_clock_oe_out |-> !master_clock_out)
    else $error("master clock driven in slave role");
  AST_MASTER_MCLK_RUNS: assert property (frame_clock_oe_out && $past(frame_clock_oe_out)
    |-> mclk_edge) else $error("master clock stalled");
  AST_BCLK_PAIR: assert property (receive_bit_clock_out == transmit_bit_clock_out)
    else $error("bit clock outputs differ");
  AST_RD_UNMAPPED: assert property (reg_rd_in && ce_in && reg_addr_in != 8'h00
    |=> reg_rdata_out == 32'h0000_0000) else $error("unmapped read not zero");
  AST_RD_HOLDS: assert property (!(reg_rd_in && ce_in) |=> $stable(reg_rdata_out))
    else $error("read data moved");
  AST_TDM_RX_LINES: assert property (tdm_in_held |-> rx_valid_out[3:1] == 3'h0)
    else $error("word on idle line in TDM");
  AST_TDM_TX_LINES: assert property (tdm_out_held
    |-> !(serial_out_second || serial_out_third || serial_out_fourth))
    else $error("idle line driven in TDM");
  AST_RX_ONE_CYCLE: assert property (rx_valid_out[0] |=> !rx_valid_out[0])
    else $error("receive strobe too long");
endmodule
bind serial_audio_port sap_chk sap_chk_i (.*);

// >>> verif/sap_partner.sv
// Far-side audio device supplying clocks and data
module sap_partner (
  input wire logic run_in, // Frames sent while high
  input wire logic [31:0] pat_in, // Left word; right word is its inverse
  input wire logic [3:0] sdo_in, // Serial outputs of the port
  output logic mclk_out,
  output logic bclk_out,
  output logic lrclk_out,
  output logic [3:0] sdi_out,
  output logic [127:0] cap_l_out,
  output logic [127:0] cap_r_out,
  output int frames_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [127:0] cap; // Words being captured
  logic [31:0] w; // Word of the current half
  // Free master clock near 12.2 MHz, no integer ratio to the frame rate
  initial mclk_out = 1'b0;
  always #41 mclk_out = ~mclk_out;
  // Left-justified frames of 64 bit clocks, bit clock idles high between frames
  initial begin
    bclk_out = 1'b1;
    lrclk_out = 1'b0;
    sdi_out = 4'h0;
    cap_l_out = '0;
    cap_r_out = '0;
    frames_out = 0;
    forever begin
      wait (run_in);
      for (int h = 0; h < 2; h++) begin
        w = h ? ~pat_in : pat_in;
        for (int b = 31; b >= 0; b--) begin
          bclk_out = 1'b0;
          lrclk_out = !h;
          for (int i = 0; i < 4; i++) sdi_out[i] = w[(b + 8 * i) % 32];
          #100 bclk_out = 1'b1;
          #95;
          for (int i = 0; i < 4; i++) cap[32 * i + b] = sdo_in[i];
          #5;
        end
        if (h == 0) cap_l_out = cap;
        else cap_r_out = cap;
      end
      frames_out++;
      // Released lines invert
      if (!run_in) sdi_out = ~sdi_out;
    end
  end
endmodule

// >>> verif/multichannel_audio_serial_port_bench.sv
// Testbench of the serial audio port
`include "sap_defs.vh"
module multichannel_audio_serial_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic [127:0] tx_word_in = '0;
  logic tx_valid_in = 1'b0;
  logic run_q = 1'b0; // Partner sends frames
  logic [31:0] pat = 32'hC35A_9617; // Left word
  wire [31:0] reg_rdata_out;
  wire mclk, bclk, lrclk, fclk_in, mclk_o, rbclk, tbclk, fclk_o, fclk_oe, tx_ready_out;
  wire [3:0] sdi, sdo, rx_valid_out;
  wire [191:0] rx_word_out;
  wire [2:0] rx_chan_out;
  wire [127:0] cap_l, cap_r;
  int frames;
  int bad_count = 0; // Mismatches
  int num_checks = 0; // Comparisons
  // Frame clock pin, driven by the port in master role
  assign fclk_in = fclk_oe ? fclk_o : lrclk;
  always #12.5 clock_in = ~clock_in;
  serial_audio_port serial_audio_port_i (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .master_clock_input(mclk),
    .master_clock_out(mclk_o), .bit_clock_in(bclk), .receive_bit_clock_out(rbclk),
    .transmit_bit_clock_out(tbclk), .frame_clock_in(fclk_in), .frame_clock_out(fclk_o),
    .frame_clock_oe_out(fclk_oe), .serial_in_primary(sdi[0]), .serial_in_second(sdi[1]),
    .serial_in_third(sdi[2]), .serial_in_fourth(sdi[3]), .serial_out_primary(sdo[0]),
    .serial_out_second(sdo[1]), .serial_out_third(sdo[2]), .serial_out_fourth(sdo[3]),
    .tx_word_in(tx_word_in), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
    .rx_word_out(rx_word_out), .rx_valid_out(rx_valid_out), .rx_chan_out(rx_chan_out));
  sap_partner sap_partner_i (.run_in(run_q), .pat_in(pat), .sdo_in(sdo), .mclk_out(mclk),
    .bclk_out(bclk), .lrclk_out(lrclk), .sdi_out(sdi), .cap_l_out(cap_l), .cap_r_out(cap_r),
    .frames_out(frames));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clock_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clock_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clock_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge clock_in);
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
  endtask
  task automatic test_done;
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, unmapped address refused
  task automatic t_regs;
    logic [31:0] d;
    rd(8'h00, d);
    chk(d[16:0], `CTRL_RESET);
    chk({fclk_oe, mclk_o}, 2'b00);
    wr(8'h00, 32'h0000_5A3E);
    rd(8'h00, d);
    chk({d[23:17], d[16:0]}, {7'h00, 17'h05A3E});
    wr(8'h04, 32'h0001_FFFF);
    rd(8'h00, d);
    chk(d[16:0], 17'h05A3E);
    rd(8'h04, d);
    chk(d, 32'h0000_0000);
  endtask
  // Master role: dividers, frame half, TDM idle lines
  task automatic t_master;
    int n, k;
    logic p;
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'h0000_2007 | (m << 11));
      repeat (8) @(negedge clock_in);
      n = 0;
      p = mclk_o;
      repeat (60) begin
        @(negedge clock_in);
        if (mclk_o !== p) n++;
        p = mclk_o;
      end
      chk(n, 60 / ((m > 2 ? 2 : m) + 1));
      chk(fclk_oe, 1'b1);
    end
    wr(8'h00, 32'h0000_2007);
    for (k = 0; k < 2000 && fclk_o !== 1'b0; k++) @(negedge clock_in);
    for (k = 0; k < 2000 && fclk_o !== 1'b1; k++) @(negedge clock_in);
    n = 0;
    p = rbclk;
    for (k = 0; k < 2000 && fclk_o === 1'b1; k++) begin
      @(negedge clock_in);
      if (rbclk === 1'b1 && p === 1'b0) n++;
      p = rbclk;
    end
    chk(n, 32);
    wr(8'h00, 32'h0000_207F);
    p = 1'b0;
    repeat (700) begin
      @(negedge clock_in);
      p = p | sdo[1] | sdo[2] | sdo[3] | (|rx_valid_out[3:1]);
    end
    chk(p, 1'b0);
    // Hand over just after a frame clock fall
    wait (fclk_o === 1'b1);
    wait (fclk_o === 1'b0);
  endtask
  // Slave role: frames both ways, underrun
  task automatic t_slave;
    logic [127:0] ent [4];
    logic [31:0] d;
    logic [63:0] x;
    int n, f, g;
    for (int i = 0; i < 4; i++)
      ent[i] = {32'hA1B2C3D4 + i, 32'h5E6F7081 - i, 32'h13579BDF ^ i, 32'h80F0E1D2 + i};
    wr(8'h00, 32'h0800_2006);
    rd(8'h00, d);
    chk({d[27], fclk_oe}, 2'b00);
    for (int i = 0; i < 4; i++) begin
      @(negedge clock_in);
      chk(tx_ready_out, 1'b1);
      tx_valid_in = 1'b1;
      tx_word_in = ent[i];
      @(negedge clock_in);
      tx_valid_in = 1'b0;
    end
    chk(tx_ready_out, 1'b0);
    run_q = 1'b1;
    n = 0;
    f = 0;
    g = 0;
    for (int k = 0; k < 3000 && g < 20; k++) begin
      @(negedge clock_in);
      for (int i = 0; i < 4; i++) if (rx_valid_out[i] === 1'b1) begin
        x = rx_chan_out[0] ? {~pat, ~pat} : {pat, pat};
        x = x >> (8 * i);
        chk(rx_word_out[48 * i +: 48], {x[31:0], 16'h0000});
        n++;
      end
      if (frames != f) begin
        f = frames;
        chk(cap_l, f < 3 ? ent[2 * f - 2] : 128'h0);
        chk(cap_r, f < 3 ? ent[2 * f - 1] : 128'h0);
        if (f == 2) run_q = 1'b0;
      end
      if (f == 3) g++;
    end
    chk(n, 24);
    rd(8'h00, d);
    chk(d[27], 1'b1);
    wr(8'h00, 32'h0800_2006);
    rd(8'h00, d);
    chk({d[27], d[25], d[24]}, 3'b010);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clock_in);
    rst_in = 1'b0;
    t_regs;
    t_master;
    t_slave;
    test_done;
  end
  initial begin
    #400000;
    bad_count++;
    test_done;
  end
endmodule
